/* File: rio_consts.svh */
// Constants for the remote I/O port configuration block.
`ifndef RIO_CONSTS_SVH
`define RIO_CONSTS_SVH

`define RIO_GRP_W          8
`define RIO_TRG_W          4
`define RIO_TRG_EXT_A      4'h6
`define RIO_TRG_EXT_B      4'h7
`define RIO_MAX_NODES      15
`define RIO_TOKEN_HOLD_CYC 16'h0040

`define RIO_OFF_CFG        32'h0000_0000
`define RIO_OFF_OUT_A      32'h0000_0004
`define RIO_OFF_OUT_B      32'h0000_0008
`define RIO_OFF_OUT_C      32'h0000_000c
`define RIO_OFF_STATUS     32'h0000_0010
`define RIO_OFF_IN_C       32'h0000_0014
`define RIO_OFF_TOKEN      32'h0000_0018

`define RIO_CFG_A_TYPE     0
`define RIO_CFG_B_TYPE     1
`define RIO_CFG_C_TYPE     2
`define RIO_CFG_TRG_LSB    4
`define RIO_CFG_VALID      8

`define RIO_RESP_OKAY      2'b00
`define RIO_RESP_SLVERR    2'b10

`endif

/* File: rio_grp_drive.sv */
// Drive stage for one 8-bit port group.
`timescale 1ns/1ps
`include "rio_consts.svh"
module rio_grp_drive #(
    parameter int W = `RIO_GRP_W
) (
    input  wire logic                aclk,     // Clock.
    input  wire logic                aresetn,  // Synchronous reset, active low.
    input  wire logic                is_out,   // Group acts as output.
    input  wire logic                od,       // Open-drain drive selected.
    input  wire logic [W-1:0]        data,     // Value to present.
    output rio_pkg::rio_pins_t       pins      // Registered pin drive.
);
    // Open-drain drives only lows; enable is low while driving.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pins.out_val <= 8'h00;
            pins.oe_n    <= 8'hff;
        end
        else
        begin
            pins.out_val <= is_out ? data : 8'h00;
            for (int i = 0; i < W; i++)
            begin
                pins.oe_n[i] <= !(is_out && (!od || !data[i]));
            end
        end
    end
endmodule : rio_grp_drive

/* File: rio_pkg.sv */
// Types shared by the remote I/O port configuration block.
package rio_pkg;

    typedef struct packed {
        logic       cfg_valid;
        logic [3:0] trg_sel;
        logic       c_type;
        logic       b_type;
        logic       a_type;
    } rio_cfg_t;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] oe_n;
    } rio_pins_t;

    typedef enum logic [1:0] {
        RIO_TOK_IDLE,
        RIO_TOK_MASTER,
        RIO_TOK_PASS
    } rio_tok_t;

endpackage : rio_pkg

/* File: rio_port_cfg.sv */
// Remote I/O port configuration and drive for three port groups.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "rio_consts.svh"
module rio_port_cfg (
    input  wire logic        aclk,               // Clock, 200 MHz.
    input  wire logic        aresetn,            // Synchronous reset, active low.
    input  wire logic [31:0] s_axi_awaddr,       // Write address.
    input  wire logic        s_axi_awvalid,      // Write address valid.
    output logic             s_axi_awready,      // Write address ready.
    input  wire logic [31:0] s_axi_wdata,        // Write data.
    input  wire logic [3:0]  s_axi_wstrb,        // Write strobes.
    input  wire logic        s_axi_wvalid,       // Write data valid.
    output logic             s_axi_wready,       // Write data ready.
    output logic [1:0]       s_axi_bresp,        // Write response.
    output logic             s_axi_bvalid,       // Write response valid.
    input  wire logic        s_axi_bready,       // Write response ready.
    input  wire logic [31:0] s_axi_araddr,       // Read address.
    input  wire logic        s_axi_arvalid,      // Read address valid.
    output logic             s_axi_arready,      // Read address ready.
    output logic [31:0]      s_axi_rdata,        // Read data.
    output logic [1:0]       s_axi_rresp,        // Read response.
    output logic             s_axi_rvalid,       // Read data valid.
    input  wire logic        s_axi_rready,       // Read data ready.
    input  wire logic        grp_c_dir_strap,    // Group C direction strap.
    input  wire logic        token_in,           // Token received pulse.
    input  wire logic        tx_done,            // Own transmission complete pulse.
    output logic             token_pass,         // Token passed to neighbour pulse.
    output logic             token_master,       // Node holds the network.
    output logic [7:0]       grp_a_lines_o,      // Group A output values.
    output logic [7:0]       grp_a_lines_oe_n,   // Group A enables, low drives.
    output logic [7:0]       grp_b_lines_o,      // Group B output values.
    output logic [7:0]       grp_b_lines_oe_n,   // Group B enables, low drives.
    input  wire logic        grp_c_line0_i,      // Group C bit 0 input.
    output logic             grp_c_line0_o,      // Group C bit 0 output.
    output logic             grp_c_line0_oe_n,   // Group C bit 0 enable, low drives.
    input  wire logic [6:0]  grp_c_upper_lines_i,  // Group C bits 1-7 input.
    output logic [6:0]       grp_c_upper_lines_o,  // Group C bits 1-7 output.
    output logic [6:0]       grp_c_upper_lines_oe_n, // Group C bits 1-7 enables.
    output logic             ext_trigger_in_1_n  // External trigger, active low.
);
    rio_pkg::rio_cfg_t  cfg_reg;
    logic [7:0]         out_a_reg;
    logic [7:0]         out_b_reg;
    logic [7:0]         out_c_reg;
    logic [7:0]         in_c_reg;
    logic               strap_reg;
    logic               strap_taken_reg;
    logic               trig_en_reg;
    logic               trig_reg;
    logic [31:0]        awaddr_reg;
    logic [31:0]        wdata_reg;
    logic [3:0]         wstrb_reg;
    logic               aw_have_reg;
    logic               w_have_reg;
    logic               bvalid_reg;
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;
    logic [1:0]         bresp_reg;
    rio_pkg::rio_tok_t  tok_reg;
    logic [15:0]        tok_cnt_reg;
    logic [3:0]         node_cnt_reg;
    logic               do_write;
    logic               c_is_out;
    logic               trig_sel_hit;
    logic               wr_ok;
    logic [7:0]         c_data;
    rio_pkg::rio_pins_t pins_a;
    rio_pkg::rio_pins_t pins_b;
    rio_pkg::rio_pins_t pins_c;

    // Write channel: address and data accepted in either order.
    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign do_write      = aw_have_reg && w_have_reg && !bvalid_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 32'h0000_0000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_comb
    begin
        unique case ({awaddr_reg[31:2], 2'b00})
            `RIO_OFF_CFG,
            `RIO_OFF_OUT_A,
            `RIO_OFF_OUT_B,
            `RIO_OFF_OUT_C:  wr_ok = 1'b1;
            default:         wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `RIO_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? `RIO_RESP_OKAY : `RIO_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Drive types come from the host over the network; reset leaves open-drain.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg <= '{cfg_valid: 1'b0, trg_sel: 4'h0, c_type: 1'b1,
                         b_type: 1'b1, a_type: 1'b1};
        end
        else if (do_write && wr_ok && wstrb_reg[0]
                 && {awaddr_reg[31:2], 2'b00} == `RIO_OFF_CFG)
        begin
            cfg_reg.a_type  <= wdata_reg[`RIO_CFG_A_TYPE];
            cfg_reg.b_type  <= wdata_reg[`RIO_CFG_B_TYPE];
            cfg_reg.c_type  <= wdata_reg[`RIO_CFG_C_TYPE];
            cfg_reg.trg_sel <= wdata_reg[`RIO_CFG_TRG_LSB +: `RIO_TRG_W];
            cfg_reg.cfg_valid <= 1'b1;
        end
        else if (do_write && wr_ok && wstrb_reg[1]
                 && {awaddr_reg[31:2], 2'b00} == `RIO_OFF_CFG)
        begin
            cfg_reg.cfg_valid <= wdata_reg[`RIO_CFG_VALID];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_a_reg <= 8'h00;
            out_b_reg <= 8'h00;
            out_c_reg <= 8'h00;
        end
        else if (do_write && wstrb_reg[0])
        begin
            if ({awaddr_reg[31:2], 2'b00} == `RIO_OFF_OUT_A)
            begin
                out_a_reg <= wdata_reg[7:0];
            end
            if ({awaddr_reg[31:2], 2'b00} == `RIO_OFF_OUT_B)
            begin
                out_b_reg <= wdata_reg[7:0];
            end
            if ({awaddr_reg[31:2], 2'b00} == `RIO_OFF_OUT_C)
            begin
                out_c_reg <= wdata_reg[7:0];
            end
        end
    end

    // Strap is caught once on the first clock after reset release.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_reg       <= 1'b0;
            strap_taken_reg <= 1'b0;
        end
        else if (!strap_taken_reg)
        begin
            strap_reg       <= grp_c_dir_strap;
            strap_taken_reg <= 1'b1;
        end
    end

    // Until configuration is applied, every group stays an open-drain output.
    assign c_is_out     = !cfg_reg.cfg_valid || strap_reg;
    assign trig_sel_hit = (cfg_reg.trg_sel == `RIO_TRG_EXT_A)
                       || (cfg_reg.trg_sel == `RIO_TRG_EXT_B);
    assign c_data       = out_c_reg;

    // Groups A and B are outputs only; the strap sets only the direction of group C.
    rio_grp_drive #(.W(`RIO_GRP_W)) u_drv_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .is_out  (1'b1),
        .od      (cfg_reg.a_type || !cfg_reg.cfg_valid),
        .data    (out_a_reg),
        .pins    (pins_a)
    );

    rio_grp_drive #(.W(`RIO_GRP_W)) u_drv_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .is_out  (1'b1),
        .od      (cfg_reg.b_type || !cfg_reg.cfg_valid),
        .data    (out_b_reg),
        .pins    (pins_b)
    );

    // One drive stage covers all eight bits of group C alike.
    rio_grp_drive #(.W(`RIO_GRP_W)) u_drv_c (
        .aclk    (aclk),
        .aresetn (aresetn),
        .is_out  (c_is_out),
        .od      (cfg_reg.c_type || !cfg_reg.cfg_valid),
        .data    (c_data),
        .pins    (pins_c)
    );

    assign grp_a_lines_o          = pins_a.out_val;
    assign grp_a_lines_oe_n       = pins_a.oe_n;
    assign grp_b_lines_o          = pins_b.out_val;
    assign grp_b_lines_oe_n       = pins_b.oe_n;
    assign grp_c_line0_o          = pins_c.out_val[0];
    assign grp_c_line0_oe_n       = pins_c.oe_n[0];
    assign grp_c_upper_lines_o    = pins_c.out_val[7:1];
    assign grp_c_upper_lines_oe_n = pins_c.oe_n[7:1];

    // Input capture and the external trigger on group C bit 0.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_c_reg    <= 8'h00;
            trig_en_reg <= 1'b0;
            trig_reg    <= 1'b1;
        end
        else
        begin
            in_c_reg    <= c_is_out ? 8'h00 : {grp_c_upper_lines_i, grp_c_line0_i};
            trig_en_reg <= !c_is_out && trig_sel_hit;
            trig_reg    <= trig_en_reg ? grp_c_line0_i : 1'b1;
        end
    end

    assign ext_trigger_in_1_n = trig_reg;

    // Token holding: master until sending ends or the fixed hold period runs out, then pass.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tok_reg     <= rio_pkg::RIO_TOK_IDLE;
            tok_cnt_reg <= 16'h0000;
        end
        else
        begin
            unique case (tok_reg)
                rio_pkg::RIO_TOK_IDLE:
                begin
                    if (token_in)
                    begin
                        tok_reg     <= rio_pkg::RIO_TOK_MASTER;
                        tok_cnt_reg <= `RIO_TOKEN_HOLD_CYC;
                    end
                end
                rio_pkg::RIO_TOK_MASTER:
                begin
                    if (tok_cnt_reg != 16'h0000)
                    begin
                        tok_cnt_reg <= tok_cnt_reg - 16'h0001;
                    end
                    if (tx_done || tok_cnt_reg == 16'h0000)
                    begin
                        tok_reg <= rio_pkg::RIO_TOK_PASS;
                    end
                end
                rio_pkg::RIO_TOK_PASS:
                begin
                    tok_reg <= rio_pkg::RIO_TOK_IDLE;
                end
            endcase
        end
    end

    assign token_master = (tok_reg == rio_pkg::RIO_TOK_MASTER);
    assign token_pass   = (tok_reg == rio_pkg::RIO_TOK_PASS);

    // Count of token passes, kept to the legal node range.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            node_cnt_reg <= 4'h0;
        end
        else if (token_pass)
        begin
            node_cnt_reg <= (node_cnt_reg == 4'(`RIO_MAX_NODES - 1)) ? 4'h0
                          : node_cnt_reg + 4'h1;
        end
    end

    // Read channel: one cycle after the address is taken.
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `RIO_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `RIO_RESP_OKAY;
            unique case ({s_axi_araddr[31:2], 2'b00})
                `RIO_OFF_CFG:    rdata_reg <= {23'h0, cfg_reg.cfg_valid, cfg_reg.trg_sel,
                                               1'b0, cfg_reg.c_type, cfg_reg.b_type,
                                               cfg_reg.a_type};
                `RIO_OFF_OUT_A:  rdata_reg <= {24'h0, out_a_reg};
                `RIO_OFF_OUT_B:  rdata_reg <= {24'h0, out_b_reg};
                `RIO_OFF_OUT_C:  rdata_reg <= {24'h0, out_c_reg};
                `RIO_OFF_STATUS: rdata_reg <= {28'h0, token_master, !trig_reg,
                                               trig_en_reg, c_is_out};
                `RIO_OFF_IN_C:   rdata_reg <= {24'h0, in_c_reg};
                `RIO_OFF_TOKEN:  rdata_reg <= {28'h0, node_cnt_reg};
                default:
                begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= `RIO_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule : rio_port_cfg

/* File: rio_port_cfg_sva.sv */
// Concurrent checks on the ports of the remote I/O port configuration block.
`timescale 1ns/1ps
module rio_port_cfg_chk (
    input wire logic        aclk,               // Clock.
    input wire logic        aresetn,            // Reset, active low.
    input wire logic        s_axi_awvalid,      // Aw valid.
    input wire logic        s_axi_awready,      // Aw ready.
    input wire logic        s_axi_wvalid,       // W valid.
    input wire logic        s_axi_wready,       // W ready.
    input wire logic        s_axi_bvalid,       // B valid.
    input wire logic        s_axi_bready,       // B ready.
    input wire logic        s_axi_arvalid,      // Ar valid.
    input wire logic        s_axi_arready,      // Ar ready.
    input wire logic        s_axi_rvalid,       // R valid.
    input wire logic        s_axi_rready,       // R ready.
    input wire logic [31:0] s_axi_rdata,        // Read data.
    input wire logic        token_in,           // Token received.
    input wire logic        tx_done,            // Frame done.
    input wire logic        token_pass,         // Token passed.
    input wire logic        token_master,       // Token held.
    input wire logic        grp_c_line0_i,      // Line 0 level.
    input wire logic        ext_trigger_in_1_n, // Trigger, active low.
    input wire logic [7:0]  grp_a_lines_oe_n    // Group A enables.
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    aw_to_b_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("Write response missing.");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early.");
    ar_to_r_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data missing after address.");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data not held.");
    tok_take_a: assert property (token_in && !token_master && !token_pass |=> token_master)
        else $error("Token not taken.");
    tok_pulse_a: assert property (token_pass |=> !token_pass && !token_master)
        else $error("Token pass not a single pulse.");
    tok_bound_a: assert property ($rose(token_master) |-> ##[1:66] token_pass)
        else $error("Token held too long.");
    pass_done_a: assert property (tx_done && token_master |-> ##[1:2] token_pass)
        else $error("Token not passed after frame.");
    trig_follow_a: assert property (!ext_trigger_in_1_n |-> !$past(grp_c_line0_i))
        else $error("Trigger low without cause.");
    rst_idle_a: assert property ($rose(aresetn)
        |-> (&grp_a_lines_oe_n) && ext_trigger_in_1_n && !token_master)
        else $error("Outputs not idle after reset.");

    cover property (s_axi_bvalid && !s_axi_bready);
    cover property (token_pass);
    cover property (!ext_trigger_in_1_n);
endmodule : rio_port_cfg_chk

bind rio_port_cfg rio_port_cfg_chk i_rio_port_cfg_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .token_in(token_in), .tx_done(tx_done), .token_pass(token_pass),
    .token_master(token_master), .grp_c_line0_i(grp_c_line0_i),
    .ext_trigger_in_1_n(ext_trigger_in_1_n), .grp_a_lines_oe_n(grp_a_lines_oe_n)
);

/* File: rio_ring_peer.sv */
// Ring neighbour model that hands the token to the node and ends its frame.
`timescale 1ns/1ps
module rio_ring_peer (
    input  wire logic       aclk,         // Clock.
    input  wire logic       aresetn,      // Reset, active low.
    input  wire logic       go,           // Deliver the token.
    input  wire logic [7:0] done_dly,     // Frame length, 0 never ends.
    input  wire logic       token_master, // Node holds the network.
    output logic            token_in,     // Token delivered pulse.
    output logic            tx_done       // Frame finished pulse.
);
    logic [7:0] cnt_reg;

    // The token is offered only to an idle node, one pulse per request.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            token_in <= 1'b0;
        else
            token_in <= go && !token_master;
    end

    // A zero length models a frame that never ends, so the node must let go by itself.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !token_master)
            cnt_reg <= 8'h0;
        else
            cnt_reg <= cnt_reg + 8'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_done <= 1'b0;
        else
            tx_done <= token_master && done_dly != 8'h0 && cnt_reg == done_dly - 8'h1;
    end
endmodule : rio_ring_peer

/* File: test_rio_port_cfg.sv */
// Self-checking testbench for the remote I/O port configuration block.
`timescale 1ns/1ps
`include "rio_consts.svh"
`define CHK(act, exp) \
    begin \
        n_checks++; \
        if ((act) !== (exp)) \
        begin \
            fail_count++; \
            $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); \
        end \
    end
module test_rio_port_cfg;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, cfg;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        strap = 1'b0, go = 1'b0, c0_ext = 1'b1;
    logic [6:0]  up_ext = 7'h0, up_o, up_oe_n, up_i;
    logic [7:0]  dly = 8'h0, a_o, a_oe_n, b_o, b_oe_n, da, db, dc;
    logic        awready, wready, bvalid, arready, rvalid, token_in, tx_done, token_pass;
    logic        token_master, c0_o, c0_oe_n, c0_i, trig_n, trg_hit;
    logic [1:0]  bresp, rresp;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #2.5 aclk = ~aclk;
    // Group C wire: the design's drive where enabled, otherwise the outside level.
    assign c0_i = c0_oe_n ? c0_ext : c0_o;
    assign up_i = (up_oe_n & up_ext) | (~up_oe_n & up_o);

    rio_port_cfg i_rio_port_cfg (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .grp_c_dir_strap(strap), .token_in(token_in), .tx_done(tx_done),
        .token_pass(token_pass), .token_master(token_master), .grp_a_lines_o(a_o),
        .grp_a_lines_oe_n(a_oe_n), .grp_b_lines_o(b_o), .grp_b_lines_oe_n(b_oe_n),
        .grp_c_line0_i(c0_i), .grp_c_line0_o(c0_o), .grp_c_line0_oe_n(c0_oe_n),
        .grp_c_upper_lines_i(up_i), .grp_c_upper_lines_o(up_o),
        .grp_c_upper_lines_oe_n(up_oe_n), .ext_trigger_in_1_n(trig_n)
    );

    rio_ring_peer i_rio_ring_peer (
        .aclk(aclk), .aresetn(aresetn), .go(go), .done_dly(dly),
        .token_master(token_master), .token_in(token_in), .tx_done(tx_done)
    );

    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fail_count++;
            finish_test();
        end
    end

    function automatic logic [7:0] exp_oe_n(input logic [7:0] d, input logic od, input logic out);
        return !out ? 8'hff : (od ? d : 8'h00);
    endfunction : exp_oe_n

    // Enabled bits must carry the data; open-drain enables only the zero bits.
    task automatic chk_pins(input logic [7:0] o, oe_n, d, input logic od, out);
        `CHK(oe_n, exp_oe_n(d, od, out))
        `CHK(o | oe_n, d | exp_oe_n(d, od, out))
    endtask : chk_pins

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    task automatic do_reset(input logic s);
        @(posedge aclk);
        aresetn <= 1'b0;
        strap <= s;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    task automatic axi_op(input logic wr, input logic [31:0] a, d, input logic [1:0] er);
        int   n;
        int   hold;
        logic aw_hs, w_hs, ar_hs, r_hs;
        n = 0;
        hold = $urandom % 5;
        r_hs = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'h1;
        araddr <= a;
        awvalid <= wr;
        wvalid <= wr;
        arvalid <= !wr;
        while (!r_hs && n < 200)
        begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            ar_hs = arvalid && arready;
            r_hs = wr ? bvalid && bready : rvalid && rready;
            if (r_hs && wr) `CHK(bresp, er)
            if (r_hs && !wr) `CHK({rresp, rdata}, {er, d})
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) {bready, rready} <= 2'b00;
            else if (n >= hold) {bready, rready} <= {wr, !wr};
            n++;
        end
        `CHK(r_hs, 1'b1)
    endtask : axi_op

    task automatic pass_tok(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        go <= 1'b1;
        dly <= d;
        @(posedge aclk);
        go <= 1'b0;
        do
        begin
            @(negedge aclk);
            n++;
        end
        while (!token_pass && n < 100);
        `CHK(n >= (d == 8'h0 ? 60 : d) && n <= (d == 8'h0 ? 72 : d + 6), 1'b1)
    endtask : pass_tok

    initial
    begin
        void'($urandom(32'h5eb0));
        for (int s = 1; s >= 0; s--)
        begin
            do_reset(s[0]);
            da = $urandom;
            db = $urandom;
            dc = $urandom;
            axi_op(1'b1, `RIO_OFF_OUT_A, {24'h0, da}, `RIO_RESP_OKAY);
            axi_op(1'b1, `RIO_OFF_OUT_B, {24'h0, db}, `RIO_RESP_OKAY);
            axi_op(1'b1, `RIO_OFF_OUT_C, {24'h0, dc}, `RIO_RESP_OKAY);
            settle(3);
            chk_pins(a_o, a_oe_n, da, 1'b1, 1'b1);
            chk_pins({up_o, c0_o}, {up_oe_n, c0_oe_n}, dc, 1'b1, 1'b1);
            cfg = $urandom & 32'h7;
            axi_op(1'b1, `RIO_OFF_CFG, cfg, `RIO_RESP_OKAY);
            settle(3);
            chk_pins(a_o, a_oe_n, da, cfg[0], 1'b1);
            chk_pins(b_o, b_oe_n, db, cfg[1], 1'b1);
            chk_pins({up_o, c0_o}, {up_oe_n, c0_oe_n}, dc, cfg[2], s[0]);
            axi_op(1'b0, `RIO_OFF_OUT_B, {24'h0, db}, `RIO_RESP_OKAY);
        end
        @(posedge aclk);
        da = $urandom;
        up_ext <= da[6:0];
        settle(4);
        axi_op(1'b0, `RIO_OFF_IN_C, {24'h0, da[6:0], 1'b1}, `RIO_RESP_OKAY);
        for (int t = 0; t < 16; t++)
        begin
            axi_op(1'b1, `RIO_OFF_CFG, (32'(t) << 4) | ($urandom & 32'h7), `RIO_RESP_OKAY);
            trg_hit = (t[3:0] == `RIO_TRG_EXT_A) || (t[3:0] == `RIO_TRG_EXT_B);
            for (int v = 0; v < 2; v++)
            begin
                @(posedge aclk);
                c0_ext <= v[0];
                settle(4);
                `CHK(trig_n, v[0] || !trg_hit)
                axi_op(1'b0, `RIO_OFF_STATUS, {29'h0, !v[0] && trg_hit, trg_hit, 1'b0},
                       `RIO_RESP_OKAY);
            end
        end
        axi_op(1'b0, 32'h0000_0040, 32'h0, `RIO_RESP_SLVERR);
        axi_op(1'b1, `RIO_OFF_STATUS, 32'hff, `RIO_RESP_SLVERR);
        for (int i = 0; i < 16; i++)
            pass_tok((i % 4 == 0) ? 8'h0 : 8'(1 + $urandom % 20));
        axi_op(1'b0, `RIO_OFF_TOKEN, 32'h1, `RIO_RESP_OKAY);
        finish_test();
    end
endmodule : test_rio_port_cfg
